// ===== src/clk_gate_pkg.sv
// constants for the pin and downstream clock gating register block
package clk_gate_pkg;
	localparam int unsigned PIN_COUNT       = 4;
	localparam int unsigned SLOT_COUNT      = 4;
	localparam int unsigned DEV_COUNT       = 5;
	localparam int unsigned CLK_OUT_COUNT   = 10;
	localparam logic [7:0]  DWORD_PIN_ADDR  = 8'h64;
	localparam logic [7:0]  DWORD_CLK_ADDR  = 8'h68;
	localparam logic [7:0]  PIN_DATA_OFS    = 8'h65;
	localparam logic [7:0]  PIN_DIR_OFS     = 8'h66;
	localparam logic [7:0]  PIN_IN_OFS      = 8'h67;
	localparam logic [7:0]  CLK_GATE_OFS    = 8'h68;
	localparam int unsigned DATA_CLR_LSB    = 8;
	localparam int unsigned DATA_SET_LSB    = 12;
	localparam int unsigned DIR_CLR_LSB     = 16;
	localparam int unsigned DIR_SET_LSB     = 20;
	localparam int unsigned IN_LSB          = 28;
	localparam int unsigned DEV_GATE_LSB    = 8;
	localparam int unsigned SELF_GATE_BIT   = 13;
	localparam int unsigned GATE_WIDTH      = 14;
	localparam logic [3:0]  PIN_RESET       = 4'h0;
	localparam logic [13:0] GATE_RESET      = 14'h0000;
	localparam logic [4:0]  SHIFT_LAST      = 5'h0d;
	typedef enum logic [1:0] {
		LD_IDLE  = 2'b00,
		LD_SHIFT = 2'b01,
		LD_DONE  = 2'b11
	} load_state_t;
endpackage

// ===== src/clk_gate_cell.sv
// one downstream clock output gate, held high when stopped
`timescale 1ns/1ps
`default_nettype none
module clk_gate_cell (
	input  wire logic ref_clk,
	input  wire logic nrst,
	input  wire logic src_clk,
	input  wire logic stop,
	output var  logic clk_out
);
	logic stop_q;
	logic stop_d;

	// stop changes only while the source is low, so no runt pulse
	always_comb begin
		stop_d = src_clk ? stop_q : stop;
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			stop_q <= 1'b0;
		end else begin
			stop_q <= stop_d;
		end
	end

	assign clk_out = src_clk | stop_q;
endmodule
`default_nettype wire

// ===== src/pin_clock_regs.sv
// configuration register bank for four general pins and downstream clock gating
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - writing one to a data-clear bit drives that pin low when bidirectional
// - writing one to a data-set bit with its data-clear bit zero drives that pin high when bidirectional
// - new pin data appears the clock after the configuration write
// - input-only pins stay undriven whatever data is written
// - zeros written to data set or clear bits leave pin data unchanged
// - data and direction fields read back last write; all reset to zero
// - writing one to a direction-clear bit makes that pin input only
// - writing one to a direction-set bit with its direction-clear bit zero enables its driver with stored data
// - zeros leave direction unchanged; after reset all pins input only
// - sampled pin levels read back in a read-only four-bit field
// - the input field updates four clocks after a pin change
// - reserved bits of the input byte and clock register read zero
// - a slot clock stops high only when both its disable bits are one
// - a slot clock runs while either disable bit is zero
// - bits 8 to 12 each stop one device clock high when set
// - bit 13 stops the fed-back bridge clock high when set
// - a secondary bus reset that starts while no load is running reloads the disable bits from a serial stream
// - each slot field is loaded from that slot's two presence lines
module pin_clock_regs #(
	parameter int unsigned PINS = clk_gate_pkg::PIN_COUNT
) (
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic        cfg_wr,
	input  wire logic        cfg_rd,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [3:0]  cfg_be_n,
	input  wire logic [31:0] cfg_wdata,
	output var  logic [31:0] cfg_rdata,
	input  wire logic [PINS-1:0] pin_in,
	output var  logic [PINS-1:0] pin_out,
	output var  logic [PINS-1:0] pin_oe,
	input  wire logic        sec_reset,
	input  wire logic        shift_data,
	output var  logic        shift_load,
	output var  logic        shift_clk,
	input  wire logic        sec_clk_src,
	output var  logic [9:0]  sec_clk_out
);
	logic [PINS-1:0] data_q, data_d;
	logic [PINS-1:0] dir_q, dir_d;
	logic [3:0]      dset_q, dset_d, dclr_q, dclr_d;
	logic [3:0]      eset_q, eset_d, eclr_q, eclr_d;
	logic [PINS-1:0] in_s1_q, in_s2_q, in_s3_q, in_q, in_d;
	logic [13:0]     gate_q, gate_d;
	logic [31:0]     rdata_q, rdata_d;
	logic [13:0]     shreg_q, shreg_d;
	logic [4:0]      cnt_q, cnt_d;
	clk_gate_pkg::load_state_t st_q, st_d;
	logic            sck_q, sck_d, sld_q, sld_d;
	logic [1:0]      rst_s_q;
	logic            rst_s3_q, rst_prev_q;
	logic [9:0]      stop;

	function automatic logic lane_hit(input logic [7:0] a, input logic [7:0] dw, input logic [3:0] ben,
		input int unsigned lane);
		lane_hit = (a[7:2] == dw[7:2]) && !ben[lane];
	endfunction

	wire pin_wr  = cfg_wr && (cfg_addr[7:2] == clk_gate_pkg::DWORD_PIN_ADDR[7:2]);
	wire clk_wr  = cfg_wr && (cfg_addr[7:2] == clk_gate_pkg::DWORD_CLK_ADDR[7:2]);
	wire be1_wr  = pin_wr && lane_hit(cfg_addr, clk_gate_pkg::DWORD_PIN_ADDR, cfg_be_n, 1);
	wire be2_wr  = pin_wr && lane_hit(cfg_addr, clk_gate_pkg::DWORD_PIN_ADDR, cfg_be_n, 2);
	wire rst_edge = rst_s3_q && !rst_prev_q;

	always_comb begin
		data_d = data_q;
		dir_d  = dir_q;
		dset_d = dset_q;
		dclr_d = dclr_q;
		eset_d = eset_q;
		eclr_d = eclr_q;
		if (be1_wr) begin
			dset_d = cfg_wdata[clk_gate_pkg::DATA_SET_LSB +: 4];
			dclr_d = cfg_wdata[clk_gate_pkg::DATA_CLR_LSB +: 4];
			data_d = data_q | cfg_wdata[clk_gate_pkg::DATA_SET_LSB +: PINS];
			data_d = data_d & ~cfg_wdata[clk_gate_pkg::DATA_CLR_LSB +: PINS];
		end
		if (be2_wr) begin
			eset_d = cfg_wdata[clk_gate_pkg::DIR_SET_LSB +: 4];
			eclr_d = cfg_wdata[clk_gate_pkg::DIR_CLR_LSB +: 4];
			dir_d = dir_q | cfg_wdata[clk_gate_pkg::DIR_SET_LSB +: PINS];
			dir_d = dir_d & ~cfg_wdata[clk_gate_pkg::DIR_CLR_LSB +: PINS];
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			data_q <= '0;
			dir_q  <= '0;
			dset_q <= clk_gate_pkg::PIN_RESET;
			dclr_q <= clk_gate_pkg::PIN_RESET;
			eset_q <= clk_gate_pkg::PIN_RESET;
			eclr_q <= clk_gate_pkg::PIN_RESET;
		end else begin
			data_q <= data_d;
			dir_q  <= dir_d;
			dset_q <= dset_d;
			dclr_q <= dclr_d;
			eset_q <= eset_d;
			eclr_q <= eclr_d;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pin_out <= '0;
			pin_oe  <= '0;
		end else begin
			pin_out <= data_d & dir_d;
			pin_oe  <= dir_d;
		end
	end

	// pins are asynchronous; a change counts once stages two and three agree
	always_comb begin
		in_d = in_q;
		if (in_s2_q == in_s3_q) begin
			in_d = in_s3_q;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			in_s1_q <= '0;
			in_s2_q <= '0;
			in_s3_q <= '0;
			in_q    <= '0;
		end else begin
			in_s1_q <= pin_in;
			in_s2_q <= in_s1_q;
			in_s3_q <= in_s2_q;
			in_q    <= in_d;
		end
	end

	// serial load of the disable bits, one bit per shift clock pair
	always_comb begin
		st_d    = st_q;
		cnt_d   = cnt_q;
		shreg_d = shreg_q;
		sck_d   = 1'b0;
		sld_d   = 1'b0;
		gate_d  = gate_q;
		if (clk_wr && !cfg_be_n[0]) begin
			gate_d[7:0] = cfg_wdata[7:0];
		end
		if (clk_wr && !cfg_be_n[1]) begin
			gate_d[13:8] = cfg_wdata[13:8];
		end
		unique case (st_q)
			clk_gate_pkg::LD_IDLE: begin
				if (rst_edge) begin
					st_d  = clk_gate_pkg::LD_SHIFT;
					cnt_d = '0;
					sld_d = 1'b1;
				end
			end
			clk_gate_pkg::LD_SHIFT: begin
				sck_d = ~sck_q;
				if (sck_q) begin
					// presence bits arrive slot fields first
					shreg_d = {shift_data, shreg_q[13:1]};
					cnt_d   = cnt_q + 5'd1;
					if (cnt_q == clk_gate_pkg::SHIFT_LAST) begin
						st_d = clk_gate_pkg::LD_DONE;
					end
				end
			end
			clk_gate_pkg::LD_DONE: begin
				gate_d = shreg_q;
				st_d   = clk_gate_pkg::LD_IDLE;
			end
			default: begin
				st_d = clk_gate_pkg::LD_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_q       <= clk_gate_pkg::LD_IDLE;
			cnt_q      <= '0;
			shreg_q    <= '0;
			sck_q      <= 1'b0;
			sld_q      <= 1'b0;
			gate_q     <= clk_gate_pkg::GATE_RESET;
			rst_s_q    <= '0;
			rst_s3_q   <= 1'b0;
			rst_prev_q <= 1'b0;
		end else begin
			st_q       <= st_d;
			cnt_q      <= cnt_d;
			shreg_q    <= shreg_d;
			sck_q      <= sck_d;
			sld_q      <= sld_d;
			gate_q     <= gate_d;
			rst_s_q    <= {rst_s_q[0], sec_reset};
			rst_s3_q   <= rst_s_q[1];
			rst_prev_q <= rst_s3_q;
		end
	end

	assign shift_clk  = sck_q;
	assign shift_load = sld_q;

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_slot
			assign stop[g] = &gate_q[2*g +: 2];
		end
	endgenerate
	assign stop[8:4] = gate_q[12:8];
	assign stop[9] = gate_q[clk_gate_pkg::SELF_GATE_BIT];

	generate
		for (g = 0; g < 10; g++) begin : g_gate
			clk_gate_cell u_gate (
				.ref_clk (ref_clk),
				.nrst    (nrst),
				.src_clk (sec_clk_src),
				.stop    (stop[g]),
				.clk_out (sec_clk_out[g])
			);
		end
	endgenerate

	always_comb begin
		rdata_d = '0;
		if (cfg_rd && (cfg_addr[7:2] == clk_gate_pkg::DWORD_PIN_ADDR[7:2])) begin
			rdata_d[15:8]  = {dset_q, dclr_q};
			rdata_d[23:16] = {eset_q, eclr_q};
			rdata_d[31:24] = {in_q, 4'h0};
		end else if (cfg_rd && (cfg_addr[7:2] == clk_gate_pkg::DWORD_CLK_ADDR[7:2])) begin
			rdata_d[15:0] = {2'b00, gate_q};
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign cfg_rdata = rdata_q;
endmodule
`default_nettype wire

// ===== test/pin_clock_regs_assertions.sv
// port checker for the pin and clock gate registers
`timescale 1ns/1ps
`default_nettype none
module pin_clock_regs_chk #(
	parameter int unsigned PINS = 4
) (
	input wire logic            ref_clk,
	input wire logic            nrst,
	input wire logic            cfg_wr,
	input wire logic            cfg_rd,
	input wire logic [7:0]      cfg_addr,
	input wire logic [3:0]      cfg_be_n,
	input wire logic [31:0]     cfg_wdata,
	input wire logic [31:0]     cfg_rdata,
	input wire logic [PINS-1:0] pin_out,
	input wire logic [PINS-1:0] pin_oe
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	logic       dw;
	logic       ow;
	logic [3:0] ds;
	logic [3:0] dc;
	logic [3:0] os;
	logic [3:0] oc;
	assign dw = cfg_wr && cfg_addr[7:2] == 6'h19 && !cfg_be_n[1];
	assign ow = cfg_wr && cfg_addr[7:2] == 6'h19 && !cfg_be_n[2];
	// clear wins where both bits are written
	assign ds = cfg_wdata[15:12] & ~cfg_wdata[11:8];
	assign dc = cfg_wdata[11:8];
	assign os = cfg_wdata[23:20] & ~cfg_wdata[19:16];
	assign oc = cfg_wdata[19:16];
	chk_data_set_high:
		assert property (dw |=> (pin_out & $past(ds)) == ($past(ds) & pin_oe))
			else $error("set bit not driven high");
	chk_data_clr_low:
		assert property (dw |=> (pin_out & $past(dc)) == 4'h0) else $error("clear bit not driven low");
	chk_data_stable:
		// a direction write legally moves pin_out, so it is left out here
		assert property (!ow && (!dw || cfg_wdata[15:8] == 8'h00) |=> $stable(pin_out))
			else $error("pin data moved");
	chk_dir_set_on:
		assert property (ow |=> (pin_oe & $past(os)) == $past(os)) else $error("driver not enabled");
	chk_dir_clr_off:
		assert property (ow |=> (pin_oe & $past(oc)) == 4'h0) else $error("driver not tristated");
	chk_dir_stable:
		assert property (!ow || cfg_wdata[23:16] == 8'h00 |=> $stable(pin_oe)) else $error("direction moved");
	chk_in_rsvd_zero:
		assert property (cfg_rd && cfg_addr == 8'h64 |=> cfg_rdata[27:24] == 4'h0) else $error("input pad bits set");
	chk_gate_rsvd_zero:
		assert property (cfg_rd && cfg_addr == 8'h68 |=> cfg_rdata[15:14] == 2'h0) else $error("gate pad bits set");
endmodule
bind pin_clock_regs pin_clock_regs_chk #(.PINS(PINS)) chk (.ref_clk(ref_clk), .nrst(nrst), .cfg_wr(cfg_wr),
	.cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be_n(cfg_be_n), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
	.pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire

// ===== test/presence_stream.sv
// serial presence stream source for the clock gate load
`timescale 1ns/1ps
`default_nettype none
module presence_stream #(
	parameter logic [13:0] PATTERN = 14'h1ac7
) (
	input  wire logic ref_clk,
	input  wire logic shift_load,
	input  wire logic shift_clk,
	output var  logic shift_data
);
	int   idx = 14;
	logic clk_q = 1'b0;
	// slot pairs mirror the presence lines
	always @(posedge ref_clk) begin
		clk_q <= shift_clk;
		if (shift_load)
			idx <= 0;
		else if (clk_q && !shift_clk && idx < 14)
			idx <= idx + 1;
	end
	// past the last bit the line no longer holds data
	assign shift_data = (idx < 14) ? PATTERN[idx] : ~PATTERN[13];
endmodule
`default_nettype wire

// ===== test/pin_clock_regs_tb.sv
// testbench for the pin and clock gate register block
`timescale 1ns/1ps
`default_nettype none
module pin_clock_regs_tb;
	logic        ref_clk, nrst, cfg_wr, cfg_rd, sec_reset, sec_clk_src, shift_data, shift_load, shift_clk;
	logic [7:0]  cfg_addr;
	logic [3:0]  cfg_be_n, pin_in, pin_out, pin_oe;
	logic [31:0] cfg_wdata, cfg_rdata, rd;
	logic [9:0]  sec_clk_out, last, moved;
	int          miscompares, comparisons;
	pin_clock_regs dut (.ref_clk(ref_clk), .nrst(nrst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
		.cfg_be_n(cfg_be_n), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .sec_reset(sec_reset), .shift_data(shift_data), .shift_load(shift_load),
		.shift_clk(shift_clk), .sec_clk_src(sec_clk_src), .sec_clk_out(sec_clk_out));
	presence_stream far (.ref_clk(ref_clk), .shift_load(shift_load), .shift_clk(shift_clk), .shift_data(shift_data));
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		sec_clk_src <= ~sec_clk_src;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		@(posedge ref_clk) #1;
		cfg_wr = 1'b1;
		cfg_addr = a;
		cfg_be_n = be;
		cfg_wdata = d;
		@(posedge ref_clk) #1;
		cfg_wr = 1'b0;
	endtask
	task automatic rdr(input logic [7:0] a);
		@(posedge ref_clk) #1;
		cfg_rd = 1'b1;
		cfg_addr = a;
		@(posedge ref_clk) #1;
		cfg_rd = 1'b0;
		rd = cfg_rdata;
	endtask
	task automatic t_pins;
		rdr(8'h64);
		check("reset fields", rd & 32'h00ffff00, 0);
		check("reset dir", pin_oe, 0);
		wr(8'h64, 4'b1011, 32'h00300000);
		check("dir set", pin_oe, 4'h3);
		wr(8'h64, 4'b1101, 32'h00005000);
		check("driven", pin_out & pin_oe, 4'h1);
		check("input only", {pin_oe, pin_out}, 8'h31);
		rdr(8'h64);
		check("readback", rd[15:8], 8'h50);
		wr(8'h64, 4'b1101, 32'h0);
		check("zero write", pin_out & pin_oe, 4'h1);
		wr(8'h64, 4'b1101, 32'h00000100);
		check("cleared", pin_out & pin_oe, 4'h0);
		wr(8'h64, 4'b1101, 32'h00002200);
		check("both bits", pin_out[1], 1'b0);
		wr(8'h64, 4'b1011, 32'h00010000);
		check("dir clear", pin_oe, 4'h2);
		wr(8'h64, 4'b1011, 32'h0);
		check("dir zero", pin_oe, 4'h2);
		wr(8'h64, 4'b1011, 32'h00400000);
		check("stored drive", pin_out, 4'h4);
		pin_in = 4'ha;
		repeat (6) @(posedge ref_clk);
		rdr(8'h64);
		check("input byte", rd[31:24], 8'ha0);
	endtask
	task automatic t_gate;
		// slot 0, device 0 and the fed-back clock stopped; slot 1 half set keeps running
		wr(8'h68, 4'b1100, 32'h0000e10b);
		rdr(8'h68);
		check("gate readback", rd[15:0], 16'h210b);
		moved = 10'h0;
		last = sec_clk_out;
		repeat (40) begin
			@(posedge ref_clk) #1;
			moved = moved | (sec_clk_out ^ last);
			last = sec_clk_out;
		end
		check("running clocks", moved, 10'h1ee);
		check("held high", sec_clk_out & 10'h211, 10'h211);
	endtask
	task automatic t_load;
		@(posedge ref_clk) #1;
		sec_reset = 1'b1;
		for (int n = 0; n < 50 && shift_load !== 1'b1; n++)
			@(posedge ref_clk) #1;
		check("load start", shift_load, 1'b1);
		@(posedge ref_clk) #1;
		sec_reset = 1'b0;
		repeat (400) @(posedge ref_clk);
		rdr(8'h68);
		check("loaded gate", rd[15:0], 16'h1ac7);
		wr(8'h68, 4'b1100, 32'h0);
		sec_reset = 1'b1;
		repeat (8) @(posedge ref_clk) #1;
		sec_reset = 1'b0;
		repeat (60) @(posedge ref_clk);
		rdr(8'h68);
		check("reload gate", rd[15:0], 16'h1ac7);
	endtask
	task automatic finish_test;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#20000;
		miscompares++;
		finish_test();
	end
	initial begin
		{nrst, cfg_wr, cfg_rd, sec_reset, sec_clk_src} = 5'h0;
		{cfg_addr, cfg_be_n, cfg_wdata, pin_in} = 48'h0;
		miscompares = 0;
		comparisons = 0;
		repeat (20) @(posedge ref_clk);
		#1 nrst = 1'b1;
		t_pins();
		t_gate();
		t_load();
		finish_test();
	end
endmodule
`default_nettype wire
